//--- pkg/jpeg_quant_pkg.sv
// Constants, carriers and state types for the JPEG quantization and error handshake control.
// Assumes one clock domain; host variable and table ports come from logic on the same clock.
package jpeg_quant_pkg;

  // ----------------------------------------------------------------
  // Variable indices on the host variable port
  // ----------------------------------------------------------------
  localparam logic [2:0] IDX_CODEC_CONTROL_FLAGS   = 3'h0;
  localparam logic [2:0] IDX_QUANT_SCALE_SET_ONE   = 3'h1;
  localparam logic [2:0] IDX_QUANT_SCALE_SET_TWO   = 3'h2;
  localparam logic [2:0] IDX_QUANT_SCALE_SET_THREE = 3'h3;
  localparam logic [2:0] IDX_ERROR_WAIT_FRAME_LIM  = 3'h4;
  localparam logic [2:0] IDX_MODE_SETUP            = 3'h5;
  localparam logic [2:0] IDX_STATUS                = 3'h6;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CFG_HSHAKE_BIT  = 1;
  localparam int CFG_RETRY_BIT   = 2;
  localparam int CFG_READY_BIT   = 3;
  localparam int CFG_STDQ_BIT    = 4;
  localparam int CFG_AUTO_BIT    = 5;
  localparam int CFG_ID_LSB      = 6;
  localparam int SCALE_UPD_BIT   = 7;
  localparam int MODE_COMPRESS_BIT = 4;  // Mode setup value 16

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CFG_RST   = 8'h00;
  localparam logic [7:0] SCALE_RST = 8'h20;  // Factor 32 gives unity scaling
  localparam logic [7:0] WAIT_RST  = 8'h04;
  localparam logic [7:0] MODE_RST  = 8'h00;

  // ----------------------------------------------------------------
  // Table geometry and scaling arithmetic
  // ----------------------------------------------------------------
  localparam logic [14:0] QROUND      = 15'h0010;  // 16
  localparam int          QSHIFT      = 5;
  localparam logic [1:0]  LAST_QSET   = 2'h2;
  localparam logic [8:0]  QSET_LAST   = 9'h07f;
  localparam logic [8:0]  HUFF_LAST   = 9'h0ff;
  localparam logic [8:0]  ROM_HUFF_BASE = 9'h080;
  localparam int          QMEM_DEPTH  = 384;
  localparam int          HUFF_DEPTH  = 256;

  // ----------------------------------------------------------------
  // Carriers and state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic [2:0] idx;
    logic [7:0] wdata;
  } var_req_t;

  typedef struct packed {
    logic       wr;
    logic       sel_huff;
    logic [8:0] addr;
    logic [9:0] wdata;
  } tbl_req_t;

  typedef struct packed {
    logic capture_start;
    logic video;
    logic frame_start;
    logic frame_done;
    logic frame_err;
    logic frame_tick;
  } frame_evt_t;

  typedef enum logic [2:0] {
    ST_INIT_HUFF,
    ST_RESCALE,
    ST_IDLE,
    ST_RUN,
    ST_WAIT_ACK
  } ctrl_state_t;

  typedef struct packed {
    ctrl_state_t     state;
    logic [8:0]      cnt;
    logic [1:0]      set;
    logic            init;
    logic            active;
    logic            video;
    logic            in_frame;
    logic [7:0]      wait_cnt;
    logic [7:0]      cfg;
    logic [2:0][7:0] scale;
    logic [7:0]      wait_limit;
    logic [7:0]      mode_setup;
    logic [7:0]      var_rdata;
    logic            ok;
    logic            abort;
  } ctrl_regs_t;

endpackage

//--- src/jpeg_quant_ctrl.sv
// JPEG quantization table control and frame error handshake.
// Assumes a standard-table ROM with same-cycle read data, and an encoder that
// starts a frame only while encode_enable is high.
`timescale 1ns/1ps
`default_nettype none

module jpeg_quant_ctrl
  import jpeg_quant_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       srst,
  // Host variable port
  input  var  var_req_t   var_req,
  output logic [7:0]      var_rdata,
  // Host indirect table port
  input  var  tbl_req_t   tbl_req,
  output logic [9:0]      tbl_rdata,
  // Standard table ROM
  output logic [8:0]      std_rom_addr,
  input  wire logic [7:0] std_rom_data,
  // Encoder side
  input  var  frame_evt_t frame_evt,
  input  wire logic [6:0] enc_q_addr,
  output logic [9:0]      enc_q_data,
  input  wire logic [7:0] enc_h_addr,
  output logic [7:0]      enc_h_data,
  output logic            encode_enable,
  output logic [1:0]      qtable_id,
  output logic            tables_busy,
  // Capture status
  output logic            capture_active,
  output logic            capture_ok,
  output logic            capture_abort
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Rounded scaling; a bigger factor means a bigger quant entry
  function automatic logic [9:0] scale_q(input logic [6:0] f, input logic [7:0] q);
    logic [14:0] p;
    logic [14:0] s;
    p = 15'(f * q) + QROUND;
    s = p >> QSHIFT;
    return s[9:0];
  endfunction

  // Set and entry index into the quant memory
  function automatic logic [8:0] qaddr(input logic [1:0] set, input logic [6:0] idx);
    return {set, idx};
  endfunction

  // Wrapping set advance over the three sets
  function automatic logic [1:0] next_set(input logic [1:0] id);
    return (id >= LAST_QSET) ? 2'h0 : id + 2'h1;
  endfunction

  // ----------------------------------------------------------------
  // State and memories
  // ----------------------------------------------------------------
  ctrl_regs_t r_reg;
  ctrl_regs_t r_next;
  logic [9:0] quant_mem [QMEM_DEPTH];
  logic [7:0] huff_mem  [HUFF_DEPTH];
  logic [9:0] q_rd_reg;
  logic [7:0] h_rd_reg;
  logic [9:0] t_rd_reg;
  logic       cfg_wr;
  logic       stdq_en;
  logic [2:0] upd_pend;
  logic       pend;
  logic [1:0] pend_set;
  logic       retry_ok;
  logic       q_we;
  logic [8:0] q_waddr;
  logic [9:0] q_wdata;
  logic       h_we;
  logic [7:0] h_waddr;
  logic [7:0] h_wdata;

  // Pending rescale requests, lowest set first
  always_comb begin
    stdq_en  = r_reg.cfg[CFG_STDQ_BIT];
    upd_pend = {r_reg.scale[2][SCALE_UPD_BIT], r_reg.scale[1][SCALE_UPD_BIT],
                r_reg.scale[0][SCALE_UPD_BIT]};
    pend     = stdq_en && (upd_pend != 3'h0);
    pend_set = upd_pend[0] ? 2'h0 : (upd_pend[1] ? 2'h1 : 2'h2);
    retry_ok = r_reg.video || r_reg.cfg[CFG_RETRY_BIT];
  end

  // ----------------------------------------------------------------
  // Control next state
  // ----------------------------------------------------------------
  // Host writes first so the device's own updates win on conflict, except the update-bit and ready-bit clears, which yield to a host write
  always_comb begin
    r_next       = r_reg;
    r_next.ok    = 1'b0;
    r_next.abort = 1'b0;
    if (var_req.wr) begin
      case (var_req.idx)
        IDX_CODEC_CONTROL_FLAGS:   r_next.cfg = var_req.wdata;
        IDX_QUANT_SCALE_SET_ONE:   r_next.scale[0] = var_req.wdata;
        IDX_QUANT_SCALE_SET_TWO:   r_next.scale[1] = var_req.wdata;
        IDX_QUANT_SCALE_SET_THREE: r_next.scale[2] = var_req.wdata;
        IDX_ERROR_WAIT_FRAME_LIM:  r_next.wait_limit = var_req.wdata;
        IDX_MODE_SETUP:            r_next.mode_setup = var_req.wdata;
        default: ;
      endcase
    end
    case (var_req.idx)
      IDX_CODEC_CONTROL_FLAGS:   r_next.var_rdata = r_reg.cfg;
      IDX_QUANT_SCALE_SET_ONE:   r_next.var_rdata = r_reg.scale[0];
      IDX_QUANT_SCALE_SET_TWO:   r_next.var_rdata = r_reg.scale[1];
      IDX_QUANT_SCALE_SET_THREE: r_next.var_rdata = r_reg.scale[2];
      IDX_ERROR_WAIT_FRAME_LIM:  r_next.var_rdata = r_reg.wait_limit;
      IDX_MODE_SETUP:            r_next.var_rdata = r_reg.mode_setup;
      IDX_STATUS:                r_next.var_rdata = {r_reg.active, r_reg.video, r_reg.in_frame,
                                                     2'h0, 3'(r_reg.state)};
      default:                   r_next.var_rdata = 8'h00;
    endcase
    // Frame occupancy, so rescaling never lands mid-frame
    if (frame_evt.frame_start && encode_enable) r_next.in_frame = 1'b1;
    if (frame_evt.frame_done) r_next.in_frame = 1'b0;
    case (r_reg.state)
      ST_INIT_HUFF: begin
        r_next.cnt = r_reg.cnt + 9'h001;
        if (r_reg.cnt == HUFF_LAST) begin
          r_next.cnt   = 9'h000;
          r_next.set   = 2'h0;
          r_next.init  = 1'b1;
          r_next.state = ST_RESCALE;
        end
      end
      ST_RESCALE: begin
        r_next.cnt = r_reg.cnt + 9'h001;
        if (r_reg.cnt == QSET_LAST) begin
          r_next.cnt = 9'h000;
          // Consume the request unless the host rewrites it now
          if (!(var_req.wr && var_req.idx == 3'(r_reg.set) + 3'h1))
            r_next.scale[r_reg.set][SCALE_UPD_BIT] = 1'b0;
          if (r_reg.init && r_reg.set != LAST_QSET) begin
            r_next.set = r_reg.set + 2'h1;
          end else begin
            r_next.init  = 1'b0;
            r_next.state = r_reg.active ? ST_RUN : ST_IDLE;
          end
        end
      end
      ST_IDLE: begin
        if (pend) begin
          r_next.set   = pend_set;
          r_next.cnt   = 9'h000;
          r_next.state = ST_RESCALE;
        end else if (frame_evt.capture_start && r_reg.mode_setup[MODE_COMPRESS_BIT]) begin
          r_next.active = 1'b1;
          r_next.video  = frame_evt.video;
          r_next.state  = ST_RUN;
          if (r_reg.cfg[CFG_AUTO_BIT]) r_next.cfg[7:CFG_ID_LSB] = 2'h0;
        end
      end
      ST_RUN: begin
        if (frame_evt.frame_done && !frame_evt.frame_err) begin
          if (!r_reg.video) begin
            r_next.ok     = 1'b1;
            r_next.active = 1'b0;
            r_next.state  = ST_IDLE;
          end
        end else if (frame_evt.frame_done) begin
          if (r_reg.cfg[CFG_AUTO_BIT])
            r_next.cfg[7:CFG_ID_LSB] = next_set(r_reg.cfg[7:CFG_ID_LSB]);
          if (r_reg.cfg[CFG_HSHAKE_BIT]) begin
            r_next.wait_cnt = 8'h00;
            r_next.state    = ST_WAIT_ACK;
          end else if (!retry_ok) begin
            r_next.abort  = 1'b1;
            r_next.active = 1'b0;
            r_next.state  = ST_IDLE;
          end
        end else if (!r_reg.in_frame && !frame_evt.frame_start && pend) begin
          r_next.set   = pend_set;
          r_next.cnt   = 9'h000;
          r_next.state = ST_RESCALE;
        end
      end
      ST_WAIT_ACK: begin
        if (r_reg.cfg[CFG_READY_BIT]) begin
          if (!cfg_wr) r_next.cfg[CFG_READY_BIT] = 1'b0;
          if (retry_ok) begin
            r_next.state = ST_RUN;
          end else begin
            r_next.abort  = 1'b1;
            r_next.active = 1'b0;
            r_next.state  = ST_IDLE;
          end
        end else if (frame_evt.frame_tick) begin
          r_next.wait_cnt = r_reg.wait_cnt + 8'h01;
          if (r_reg.wait_cnt + 8'h01 >= r_reg.wait_limit) begin
            r_next.abort  = 1'b1;
            r_next.active = 1'b0;
            r_next.state  = ST_IDLE;
          end
        end
      end
      default: r_next.state = ST_IDLE;
    endcase
  end

  // State register; reset always reloads the tables
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      r_reg          <= '0;
      r_reg.state    <= ST_INIT_HUFF;
      r_reg.cfg      <= CFG_RST;
      r_reg.scale    <= {SCALE_RST, SCALE_RST, SCALE_RST};
      r_reg.wait_limit <= WAIT_RST;
      r_reg.mode_setup <= MODE_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------------------------------
  // Table memory ports
  // ----------------------------------------------------------------
  // Fill engine owns the write port; host writes are dropped while it runs
  always_comb begin
    std_rom_addr = (r_reg.state == ST_INIT_HUFF) ? ROM_HUFF_BASE + r_reg.cnt
                                                  : {2'h0, r_reg.cnt[6:0]};
    q_we    = 1'b0;
    q_waddr = tbl_req.addr;
    q_wdata = tbl_req.wdata;
    h_we    = 1'b0;
    h_waddr = tbl_req.addr[7:0];
    h_wdata = tbl_req.wdata[7:0];
    if (r_reg.state == ST_RESCALE) begin
      q_we    = 1'b1;
      q_waddr = qaddr(r_reg.set, r_reg.cnt[6:0]);
      q_wdata = scale_q(r_reg.scale[r_reg.set][6:0], std_rom_data);
    end else if (r_reg.state == ST_INIT_HUFF) begin
      h_we    = 1'b1;
      h_waddr = r_reg.cnt[7:0];
      h_wdata = std_rom_data;
    end else if (tbl_req.wr) begin
      q_we = !tbl_req.sel_huff;
      h_we = tbl_req.sel_huff && (tbl_req.addr[8] == 1'b0);
    end
  end

  // Memories and registered read ports
  always_ff @(posedge sys_clk) begin
    if (q_we) quant_mem[q_waddr] <= q_wdata;
    if (h_we) huff_mem[h_waddr] <= h_wdata;
    q_rd_reg <= quant_mem[qaddr(r_reg.cfg[7:CFG_ID_LSB], enc_q_addr)];
    h_rd_reg <= huff_mem[enc_h_addr];
    t_rd_reg <= tbl_req.sel_huff ? {2'h0, huff_mem[tbl_req.addr[7:0]]} : quant_mem[tbl_req.addr];
  end

  // Outputs
  assign var_rdata      = r_reg.var_rdata;
  assign tbl_rdata      = t_rd_reg;
  assign enc_q_data     = q_rd_reg;
  assign enc_h_data     = h_rd_reg;
  assign encode_enable  = (r_reg.state == ST_RUN);
  assign qtable_id      = r_reg.cfg[7:CFG_ID_LSB];
  assign tables_busy    = (r_reg.state == ST_INIT_HUFF) || (r_reg.state == ST_RESCALE);
  assign capture_active = r_reg.active;
  assign capture_ok     = r_reg.ok;
  assign capture_abort  = r_reg.abort;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  logic err_done;
  logic [9:0] fill_age;
  assign err_done = (r_reg.state == ST_RUN) && frame_evt.frame_done && frame_evt.frame_err;
  assign cfg_wr   = var_req.wr && (var_req.idx == IDX_CODEC_CONTROL_FLAGS);
  // Cycles since reset release, saturating; stands in for a long delay
  always_ff @(posedge sys_clk) fill_age <= srst ? 10'h000 : fill_age + 10'(fill_age != 10'h3ff);
  a_init_fill_time: assert property (fill_age == 10'(HUFF_DEPTH + QMEM_DEPTH - 1) |=>
      (r_reg.state == ST_IDLE))
    else $error("Power-up table fill did not finish in 640 cycles");
  a_scale_formula: assert property ((r_reg.state == ST_RESCALE) |->
      q_wdata == 10'(((32'(r_reg.scale[r_reg.set][6:0]) * 32'(std_rom_data)) + 16) / 32))
    else $error("Scaled quant entry does not match rounding formula");
  a_rescale_done: assert property ((r_reg.state == ST_IDLE) && pend && !var_req.wr |=>
      (r_reg.state == ST_RESCALE) ##[127:260] !r_reg.scale[pend_set][SCALE_UPD_BIT])
    else $error("Scale update request not consumed after rescale");
  a_auto_reset_id: assert property ((r_reg.state == ST_IDLE) && !pend &&
      frame_evt.capture_start && r_reg.mode_setup[MODE_COMPRESS_BIT] &&
      r_reg.cfg[CFG_AUTO_BIT] && !cfg_wr |=> (qtable_id == 2'h0))
    else $error("Table id not cleared at capture start");
  a_auto_advance: assert property (err_done && r_reg.cfg[CFG_AUTO_BIT] && !cfg_wr |=>
      qtable_id == next_set($past(qtable_id)))
    else $error("Table id did not advance after failed frame");
  a_retry_continue: assert property (err_done && !r_reg.cfg[CFG_HSHAKE_BIT] && retry_ok |=>
      encode_enable && capture_active)
    else $error("Encoding stopped despite retry or video");
  a_snap_stop: assert property (err_done && !r_reg.cfg[CFG_HSHAKE_BIT] && !retry_ok |=>
      capture_abort && !capture_active)
    else $error("Failed snapshot without retry did not terminate");
  a_halt_on_error: assert property (err_done && r_reg.cfg[CFG_HSHAKE_BIT] |=>
      !encode_enable && (r_reg.state == ST_WAIT_ACK))
    else $error("Encoding not halted for handshake");
  a_wait_timeout: assert property ((r_reg.state == ST_WAIT_ACK) && !r_reg.cfg[CFG_READY_BIT] &&
      frame_evt.frame_tick && (r_reg.wait_cnt + 8'h01 >= r_reg.wait_limit) |=>
      capture_abort ##1 !capture_abort && (r_reg.state == ST_IDLE))
    else $error("Handshake timeout did not terminate capture");
  a_no_compress: assert property ((r_reg.state == ST_IDLE) && frame_evt.capture_start &&
      !r_reg.mode_setup[MODE_COMPRESS_BIT] |=> !capture_active)
    else $error("Capture started with compression disabled");
  a_ready_clear: assert property ((r_reg.state == ST_WAIT_ACK) && r_reg.cfg[CFG_READY_BIT] &&
      !cfg_wr |=> !r_reg.cfg[CFG_READY_BIT] && (encode_enable == $past(retry_ok)))
    else $error("Host ready bit not consumed");

  c_snapshot_ok: cover property (capture_active ##[1:1000] capture_ok);
  c_ack_resume: cover property ((r_reg.state == ST_WAIT_ACK) ##[1:100] encode_enable);
  c_timeout: cover property ((r_reg.state == ST_WAIT_ACK) ##[1:100] capture_abort);
  c_run_rescale: cover property ((r_reg.state == ST_RUN) ##1 (r_reg.state == ST_RESCALE));

endmodule // jpeg_quant_ctrl

`default_nettype wire

//--- testbench/jpeg_quant_and_error_handshake_bench.sv
// Self-checking bench for the quantization control and frame error handshake.
// Assumes the package constants and a same-cycle standard table ROM model.
`timescale 1ns/1ps
`default_nettype none

module jpeg_quant_and_error_handshake_bench;
  import jpeg_quant_pkg::*;
  typedef struct packed {logic [2:0] kind; logic [9:0] val;} note_t;
  logic       sys_clk = 1'b0;
  logic       srst    = 1'b1;
  var_req_t   var_req = '0;
  tbl_req_t   tbl_req = '0;
  frame_evt_t frame_evt = '0;
  logic [6:0] enc_q_addr = '0;
  logic [7:0] enc_h_addr = '0;
  logic [7:0] var_rdata, std_rom_data, enc_h_data;
  logic [9:0] tbl_rdata, enc_q_data, dat;
  logic [8:0] std_rom_addr, a;
  logic [1:0] qtable_id;
  logic       encode_enable, tables_busy, capture_active, capture_ok, capture_abort;
  logic [6:0] fac;
  logic [7:0] lim;
  note_t      notes[$];
  note_t      nt;
  int         fails = 0;
  int         checks = 0;
  int         ok_cnt = 0;
  int         abort_cnt = 0;
  logic [7:0] rst_v [6] = '{CFG_RST, SCALE_RST, SCALE_RST, SCALE_RST, WAIT_RST, MODE_RST};

  always #25 sys_clk = ~sys_clk;

  jpeg_quant_ctrl dut (.sys_clk(sys_clk), .srst(srst), .var_req(var_req), .var_rdata(var_rdata),
    .tbl_req(tbl_req), .tbl_rdata(tbl_rdata), .std_rom_addr(std_rom_addr),
    .std_rom_data(std_rom_data), .frame_evt(frame_evt), .enc_q_addr(enc_q_addr),
    .enc_q_data(enc_q_data), .enc_h_addr(enc_h_addr), .enc_h_data(enc_h_data),
    .encode_enable(encode_enable), .qtable_id(qtable_id), .tables_busy(tables_busy),
    .capture_active(capture_active), .capture_ok(capture_ok), .capture_abort(capture_abort));

  std_table_rom_model rom (.addr(std_rom_addr), .data(std_rom_data));

  // ----------------------------------------------------------------
  // Reference arithmetic, kept apart from the design's own
  // ----------------------------------------------------------------
  function automatic logic [7:0] rom_at(input logic [8:0] ad);
    return (ad[7:0] ^ 8'ha5) + {7'h00, ad[8]};
  endfunction
  function automatic logic [9:0] qexp(input logic [6:0] f, input logic [7:0] s);
    logic [14:0] p;
    p = f * s + 15'h0010;
    return p[14:5];
  endfunction

  // ----------------------------------------------------------------
  // Drivers: inputs change only at rising edges, by non-blocking writes
  // ----------------------------------------------------------------
  task automatic tick(input int n = 1);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic wr_var(input logic [2:0] i, input logic [7:0] d);
    @(posedge sys_clk) var_req <= '{1'b1, i, d};
    @(posedge sys_clk) var_req.wr <= 1'b0;
  endtask
  task automatic wr_tbl(input logic s, input logic [8:0] ad, input logic [9:0] d);
    @(posedge sys_clk) tbl_req <= '{1'b1, s, ad, d};
    @(posedge sys_clk) tbl_req.wr <= 1'b0;
  endtask
  task automatic fevt(input logic [5:0] e);
    @(posedge sys_clk) frame_evt <= e;
    @(posedge sys_clk) frame_evt <= '0;
  endtask
  // Kind 0 variable, 1 encoder quant, 2 encoder huffman, 3 host quant read
  task automatic rd(input logic [2:0] k, input logic [8:0] ad, input logic [9:0] v);
    @(posedge sys_clk);
    case (k)
      3'd0: var_req.idx <= ad[2:0];
      3'd1: enc_q_addr <= ad[6:0];
      3'd2: enc_h_addr <= ad[7:0];
      default: tbl_req <= '{1'b0, 1'b0, ad, 10'h000};
    endcase
    tick(2);
    notes.push_back('{k, v});
  endtask
  // Flags are {encode_enable, qtable_id, capture_active}; kind 5 holds pulse counts
  task automatic flags(input logic [3:0] f);
    tick(2);
    notes.push_back('{3'd4, {6'h00, f}});
  endtask
  task automatic counts(input logic [4:0] o, input logic [4:0] b);
    notes.push_back('{3'd5, {o, b}});
  endtask
  task automatic wait_ready;
    int i;
    repeat (3) @(negedge sys_clk);
    for (i = 0; i < 1000 && tables_busy !== 1'b0; i++) @(negedge sys_clk);
    if (tables_busy !== 1'b0) begin
      fails++;
      $display("unexpected at %0t: table fill never ends", $time);
    end
  endtask

  // ----------------------------------------------------------------
  // Monitor: oldest note against what the outputs show
  // ----------------------------------------------------------------
  task automatic cmp_val(input logic [9:0] exp, input logic [9:0] obs);
    checks++;
    if (obs !== exp) begin
      fails++;
      $display("unexpected at %0t: value %h, wanted %h", $time, obs, exp);
    end
  endtask
  task automatic cmp_flags(input logic [3:0] exp, input logic [3:0] obs);
    checks++;
    if (obs !== exp) begin
      fails++;
      $display("unexpected at %0t: flags %b, wanted %b", $time, obs, exp);
    end
  endtask
  always @(posedge sys_clk) begin
    if (capture_ok === 1'b1) ok_cnt++;
    if (capture_abort === 1'b1) abort_cnt++;
  end
  always @(negedge sys_clk) begin
    while (notes.size() > 0) begin
      nt = notes.pop_front();
      case (nt.kind)
        3'd0: cmp_val(nt.val, {2'b00, var_rdata});
        3'd1: cmp_val(nt.val, enc_q_data);
        3'd2: cmp_val(nt.val, {2'b00, enc_h_data});
        3'd3: cmp_val(nt.val, tbl_rdata);
        3'd4: cmp_flags(nt.val[3:0], {encode_enable, qtable_id, capture_active});
        default: cmp_val(nt.val, {ok_cnt[4:0], abort_cnt[4:0]});
      endcase
    end
  end

  task automatic end_of_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Whole run is about a thousand cycles; this bound is far past it
  initial begin
    tick(20000);
    fails++;
    $display("unexpected at %0t: watchdog expired", $time);
    end_of_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h5e97_e9ec));
    tick(2);
    srst <= 1'b0;
    wait_ready();
    for (int i = 0; i < 6; i++) rd(3'd0, 9'(i), {2'b00, rst_v[i]});
    rd(3'd0, 9'h007, 10'h000);
    rd(3'd0, 9'h006, 10'h002);
    for (int i = 0; i < 4; i++) begin
      a = 9'($urandom % 128);
      rd(3'd1, a, qexp(7'h20, rom_at(a)));
      a = 9'($urandom % 256);
      rd(3'd2, a, {2'b00, rom_at(a + 9'h080)});
    end
    // Pick set two by identifier, then rescale it
    fac = 7'($urandom);
    wr_var(3'd0, 8'h50);
    wr_var(3'd2, {1'b1, fac});
    wait_ready();
    rd(3'd0, 9'h002, {3'b000, fac});
    for (int i = 0; i < 4; i++) begin
      a = 9'($urandom % 128);
      rd(3'd1, a, qexp(fac, rom_at(a)));
    end
    // Host overrides of both memories
    dat = 10'($urandom);
    wr_tbl(1'b0, 9'h089, dat);
    rd(3'd3, 9'h089, dat);
    rd(3'd1, 9'h009, dat);
    wr_tbl(1'b1, 9'h012, {2'b00, dat[7:0]});
    rd(3'd2, 9'h012, {2'b00, dat[7:0]});
    wr_var(3'd0, 8'h10);
    rd(3'd1, 9'h005, qexp(7'h20, rom_at(9'h005)));
    // Snapshot, automatic set choice with retry
    wr_var(3'd0, 8'h34);
    fevt(6'b100000);
    flags(4'b0000);
    wr_var(3'd5, 8'h10);
    fevt(6'b100000);
    flags(4'b1001);
    fevt(6'b001000);
    fevt(6'b000110);
    flags(4'b1011);
    fevt(6'b001000);
    fevt(6'b000100);
    flags(4'b0010);
    counts(5'd1, 5'd0);
    // Snapshot without retry ends on the first error
    wr_var(3'd0, 8'h20);
    fevt(6'b100000);
    fevt(6'b001000);
    fevt(6'b000110);
    flags(4'b0010);
    counts(5'd1, 5'd1);
    // Video keeps going and cycles through the three sets
    fevt(6'b110000);
    flags(4'b1001);
    for (int i = 1; i < 4; i++) begin
      fevt(6'b001000);
      fevt(6'b000110);
      flags({1'b1, 2'(i % 3), 1'b1});
    end
    // Handshake: halt until ready, then ready bit clears
    wr_var(3'd0, 8'h22);
    fevt(6'b001000);
    fevt(6'b000110);
    flags(4'b0011);
    wr_var(3'd0, 8'h2a);
    flags(4'b1001);
    rd(3'd0, 9'h000, 10'h022);
    // No acknowledge within the frame limit
    lim = 8'(2 + $urandom % 4);
    wr_var(3'd4, lim);
    fevt(6'b001000);
    fevt(6'b000110);
    repeat (lim - 1) fevt(6'b000001);
    flags(4'b0011);
    fevt(6'b000001);
    flags(4'b0010);
    counts(5'd1, 5'd2);
    tick(3);
    end_of_test();
  end
endmodule // jpeg_quant_and_error_handshake_bench

`default_nettype wire

//--- testbench/std_table_rom_model.sv
// Stand-in for the standard table ROM that the quantization control reads.
// Assumes an asynchronous read: data follows the address in the same cycle.
`timescale 1ns/1ps
`default_nettype none

module std_table_rom_model (
  // Lookup
  input  wire logic [8:0] addr,
  output logic      [7:0] data
);
  // ----------------------------------------------------------------
  // Content pattern
  // ----------------------------------------------------------------
  // Address-dependent, so a stuck or shifted address line shows up
  assign data = (addr[7:0] ^ 8'ha5) + {7'h00, addr[8]};
endmodule // std_table_rom_model

`default_nettype wire
